// File: rtl/stap_defines.svh
/*
  constants of the sram test access port: instruction codes, widths, reset values.
  assumes: included by bare name from the design modules stap_chain and stap_port; the package does not include it.
*/
`ifndef STAP_DEFINES_SVH
`define STAP_DEFINES_SVH
`define STAP_IR_W   3
`define STAP_ID_W   32
`define STAP_IR_CAP 3'h1
`define STAP_OP_EXT 3'h0
`define STAP_OP_IDC 3'h1
`define STAP_OP_SMZ 3'h2
`define STAP_OP_RFU 3'h3
`define STAP_OP_SMP 3'h4
`define STAP_PH_VAL 1'h1
`define STAP_BYP_CAP 1'h0
`endif

// File: rtl/stap_pkg.sv
/*
  types of the sram test access port: controller states and data register select.
  assumes: compiled before every other file of the block.
*/
package stap_pkg;
  typedef enum logic [3:0] {
    ST_TLR   = 4'b0000,
    ST_IDLE  = 4'b0001,
    ST_SELDR = 4'b0010,
    ST_CAPDR = 4'b0011,
    ST_SHDR  = 4'b0100,
    ST_EX1DR = 4'b0101,
    ST_PSDR  = 4'b0110,
    ST_EX2DR = 4'b0111,
    ST_UPDR  = 4'b1000,
    ST_SELIR = 4'b1001,
    ST_CAPIR = 4'b1010,
    ST_SHIR  = 4'b1011,
    ST_EX1IR = 4'b1100,
    ST_PSIR  = 4'b1101,
    ST_EX2IR = 4'b1110,
    ST_UPIR  = 4'b1111
  } stap_state_t;
  typedef enum logic [1:0] {
    SEL_BYP = 2'b00,
    SEL_ID  = 2'b01,
    SEL_BSR = 2'b10
  } stap_sel_t;
endpackage

// File: rtl/stap_if.sv
/*
  carrier between the tap controller and its serial register chain.
  assumes: both ends run on the test clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface stap_if #(parameter int RING_W = 8);
  logic              rst;
  logic              tdi;
  logic              tlr;
  logic              cap_ir;
  logic              sh_ir;
  logic              upd_ir;
  logic              cap_dr;
  logic              sh_dr;
  logic              exec_ld;
  logic [RING_W-1:0] ring;
  logic              ir_so;
  logic              dr_so;
  logic              hiz;
  modport ctl (output rst, tdi, tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, exec_ld, ring,
               input ir_so, dr_so, hiz);
  modport chain (input rst, tdi, tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, exec_ld, ring,
                 output ir_so, dr_so, hiz);
endinterface
`default_nettype wire

// File: rtl/stap_chain.sv
/*
  serial registers of the test port: instruction, bypass, identification, boundary.
  assumes: controls come one per state from the controller on the test clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "stap_defines.svh"
module stap_chain #(
  parameter int RING_W = 8,
  parameter int PLACE  = 2,
  // identification value is arbitrary, presence bit set
  parameter logic [`STAP_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  input wire logic tck,
  stap_if.chain    c
);
  localparam int BS_W = RING_W + PLACE;
  logic [`STAP_IR_W-1:0] ir_q, ir_d, ins_q, ins_d, ex_q, ex_d;
  logic                  byp_q, byp_d, hiz_q, hiz_d;
  logic [`STAP_ID_W-1:0] id_q, id_d;
  logic [BS_W-1:0]       bs_q, bs_d;
  stap_pkg::stap_sel_t   sel;

  // decode of the executing instruction; unlisted codes act as bypass
  // code decode
  always_comb
  begin
    unique case (ex_q)
      `STAP_OP_IDC: sel = stap_pkg::SEL_ID;
      `STAP_OP_SMZ, `STAP_OP_SMP: sel = stap_pkg::SEL_BSR;
      default: sel = stap_pkg::SEL_BYP;
    endcase
  end

  // next values of all serial and held registers
  always_comb
  begin
    ir_d = ir_q;
    // power-up reset gives the shifter a known value before its first capture
    if (c.rst)
      ir_d = `STAP_IR_CAP;
    else if (c.cap_ir)
      ir_d = `STAP_IR_CAP;
    else if (c.sh_ir)
      ir_d = {c.tdi, ir_q[`STAP_IR_W-1:1]};
    ins_d = c.tlr ? `STAP_OP_IDC : (c.upd_ir ? ir_q : ins_q);
    ex_d = c.tlr ? `STAP_OP_IDC : (c.exec_ld ? ins_d : ex_q);
    hiz_d = (ex_d == `STAP_OP_SMZ);
    byp_d = byp_q;
    id_d = id_q;
    bs_d = bs_q;
    if (sel == stap_pkg::SEL_BYP)
      byp_d = c.cap_dr ? `STAP_BYP_CAP : (c.sh_dr ? c.tdi : byp_q);
    if (sel == stap_pkg::SEL_ID)
      id_d = c.cap_dr ? ID_CODE : (c.sh_dr ? {c.tdi, id_q[`STAP_ID_W-1:1]} : id_q);
    if (sel == stap_pkg::SEL_BSR)
      bs_d = c.cap_dr ? {{PLACE{`STAP_PH_VAL}}, c.ring} : (c.sh_dr ? {c.tdi, bs_q[BS_W-1:1]} : bs_q);
  end

  // registers on the rising test clock
  // rising edge shift
  always_ff @(posedge tck)
  begin
    ir_q  <= ir_d;
    ins_q <= ins_d;
    ex_q  <= ex_d;
    hiz_q <= hiz_d;
    byp_q <= byp_d;
    id_q  <= id_d;
    bs_q  <= bs_d;
  end

  assign c.ir_so = ir_q[0];
  assign c.dr_so = (sel == stap_pkg::SEL_ID) ? id_q[0] : ((sel == stap_pkg::SEL_BSR) ? bs_q[0] : byp_q);
  assign c.hiz   = hiz_q;

  ir_cap_a: assert property (@(posedge tck) disable iff (c.rst)
    c.cap_ir |=> ir_q[1:0] == 2'h1) else $error("capture-IR pattern wrong");
  ir_hold_a: assert property (@(posedge tck) disable iff (c.rst)
    !c.cap_ir && !c.sh_ir |=> $stable(ir_q)) else $error("instruction shifter moved outside path");
  ins_upd_a: assert property (@(posedge tck) disable iff (c.rst)
    c.sh_ir && !c.tlr |=> $stable(ins_q)) else $error("instruction changed while shifting");
  ins_tlr_a: assert property (@(posedge tck) disable iff (c.rst)
    c.tlr |=> ins_q == `STAP_OP_IDC && ex_q == `STAP_OP_IDC) else $error("reset did not load id instr");
  byp_path_a: assert property (@(posedge tck) disable iff (c.rst)
    c.sh_dr && sel == stap_pkg::SEL_BYP |=> c.dr_so == $past(c.tdi)) else $error("bypass lost data");
  id_lsb_a: assert property (@(posedge tck) disable iff (c.rst)
    c.cap_dr && sel == stap_pkg::SEL_ID |=> c.dr_so == ID_CODE[0]) else $error("id lsb not first");
  bs_cap_a: assert property (@(posedge tck) disable iff (c.rst)
    c.cap_dr && sel == stap_pkg::SEL_BSR |=> bs_q == {{PLACE{1'b1}}, $past(c.ring)})
    else $error("boundary capture wrong");
  bs_sel_a: assert property (@(posedge tck) disable iff (c.rst)
    c.sh_dr && (ex_q == `STAP_OP_SMZ || ex_q == `STAP_OP_SMP) |=> c.dr_so == $past(bs_q[1]))
    else $error("boundary chain not in path");
  hiz_code_a: assert property (@(posedge tck) disable iff (c.rst)
    c.upd_ir && !c.tlr |=> c.hiz == ($past(ir_q) == `STAP_OP_SMZ)) else $error("float control wrong");
endmodule
`default_nettype wire

// File: rtl/stap_port.sv
/*
  test access port of the synchronous sram: controller state machine, pad pull-ups,
  pin sampling, falling-edge data output and the output-float crossing.
  assumes: tck is the link clock from the board test controller, unrelated to clock;
  reset is synchronous to clock and asserted at power-up.
*/
`timescale 1ns/10ps
`default_nettype none
`include "stap_defines.svh"
module stap_port #(
  parameter int RING_W = 8,
  parameter int PLACE  = 2,
  // identification value is arbitrary, presence bit set
  parameter logic [`STAP_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              tck,
  input  wire logic              tms_pin,
  input  wire logic              tms_driven,
  input  wire logic              tdi_pin,
  input  wire logic              tdi_driven,
  input  wire logic [RING_W-1:0] ring_pins,
  output logic                   tdo,
  output logic                   tdo_oe,
  output logic                   ram_out_hiz
);
  logic                   rst_m_q;
  logic                   rst_q;
  logic [RING_W-1:0]      ring_m_q;
  logic [RING_W-1:0]      ring_s_q;
  logic                   tms_v;
  logic                   tdi_v;
  stap_pkg::stap_state_t  st_q;
  stap_pkg::stap_state_t  st_d;
  logic                   tdo_q;
  logic                   tdo_d;
  logic                   oe_q;
  logic                   oe_d;
  logic                   hiz_m_q;
  logic                   hiz_m_d;
  logic                   hiz_s_q;
  logic                   hiz_s_d;
  logic                   shift_now;

  stap_if #(.RING_W(RING_W)) c ();

  // power-up reset carried into the test clock domain as a level
  // power-up reset
  always_ff @(posedge tck)
  begin
    rst_m_q <= reset;
    rst_q   <= rst_m_q;
  end

  // pads with pull-ups: a pin nobody drives reads as one
  // mode select pull-up
  assign tms_v = tms_driven ? tms_pin : 1'b1;
  assign tdi_v = tdi_driven ? tdi_pin : 1'b1;

  // memory pins belong to the ram clock, so each bit is synchronised before capture;
  // a pin in transition may still sample either way, which the capture tolerates
  always_ff @(posedge tck)
  begin
    ring_m_q <= ring_pins;
    ring_s_q <= ring_m_q;
  end

  // controller next state from mode select
  // sixteen-state graph
  always_comb
  begin
    unique case (st_q)
      stap_pkg::ST_TLR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_TLR;
        else
          st_d = stap_pkg::ST_IDLE;
      end
      stap_pkg::ST_IDLE:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_SELDR;
        else
          st_d = stap_pkg::ST_IDLE;
      end
      stap_pkg::ST_SELDR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_SELIR;
        else
          st_d = stap_pkg::ST_CAPDR;
      end
      stap_pkg::ST_CAPDR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_EX1DR;
        else
          st_d = stap_pkg::ST_SHDR;
      end
      stap_pkg::ST_SHDR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_EX1DR;
        else
          st_d = stap_pkg::ST_SHDR;
      end
      stap_pkg::ST_EX1DR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_UPDR;
        else
          st_d = stap_pkg::ST_PSDR;
      end
      stap_pkg::ST_PSDR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_EX2DR;
        else
          st_d = stap_pkg::ST_PSDR;
      end
      stap_pkg::ST_EX2DR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_UPDR;
        else
          st_d = stap_pkg::ST_SHDR;
      end
      stap_pkg::ST_UPDR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_SELDR;
        else
          st_d = stap_pkg::ST_IDLE;
      end
      stap_pkg::ST_SELIR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_TLR;
        else
          st_d = stap_pkg::ST_CAPIR;
      end
      stap_pkg::ST_CAPIR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_EX1IR;
        else
          st_d = stap_pkg::ST_SHIR;
      end
      stap_pkg::ST_SHIR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_EX1IR;
        else
          st_d = stap_pkg::ST_SHIR;
      end
      stap_pkg::ST_EX1IR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_UPIR;
        else
          st_d = stap_pkg::ST_PSIR;
      end
      stap_pkg::ST_PSIR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_EX2IR;
        else
          st_d = stap_pkg::ST_PSIR;
      end
      stap_pkg::ST_EX2IR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_UPIR;
        else
          st_d = stap_pkg::ST_SHIR;
      end
      stap_pkg::ST_UPIR:
      begin
        if (tms_v)
          st_d = stap_pkg::ST_SELDR;
        else
          st_d = stap_pkg::ST_IDLE;
      end
    endcase
  end

  // state register; there is no reset pin, so power-up is the only forced entry
  // rising edge sampling
  always_ff @(posedge tck)
  begin
    if (rst_q)
      st_q <= stap_pkg::ST_TLR;
    else
      st_q <= st_d;
  end

  // one control per state towards the serial chain
  assign c.rst    = rst_q;
  assign c.tdi    = tdi_v;
  assign c.ring   = ring_s_q;
  // reset loads default
  // loading on the entering edge means the default already acts inside the reset state
  assign c.tlr    = rst_q || (st_d == stap_pkg::ST_TLR);
  assign c.cap_ir = (st_q == stap_pkg::ST_CAPIR);
  assign c.sh_ir  = (st_q == stap_pkg::ST_SHIR);
  assign c.upd_ir = (st_q == stap_pkg::ST_UPIR);
  assign c.cap_dr = (st_q == stap_pkg::ST_CAPDR);
  assign c.sh_dr  = (st_q == stap_pkg::ST_SHDR);
  assign c.exec_ld = st_d inside {[stap_pkg::ST_IDLE:stap_pkg::ST_UPDR]};

  stap_chain #(
    .RING_W  (RING_W),
    .PLACE   (PLACE),
    .ID_CODE (ID_CODE)
  ) u_chain (
    .tck (tck),
    .c   (c)
  );

  assign shift_now = (st_q == stap_pkg::ST_SHIR) || (st_q == stap_pkg::ST_SHDR);

  // serial output and its enable; launching on the falling edge gives the
  // next device half a test clock of hold margin
  // shift-only enable
  always_comb
  begin
    oe_d  = shift_now;
    tdo_d = (st_q == stap_pkg::ST_SHIR) ? c.ir_so : c.dr_so;
    if (rst_q)
    begin
      oe_d  = 1'b0;
      tdo_d = 1'b0;
    end
  end

  always_ff @(negedge tck)
  begin
    oe_q  <= oe_d;
    tdo_q <= tdo_d;
  end

  assign tdo    = tdo_q;
  assign tdo_oe = oe_q;

  // float request crosses to the ram clock as a level through two flops;
  // the ram ignores the port entirely until an instruction asks for it
  // no effect when idle
  always_comb
  begin
    hiz_m_d = reset ? 1'b0 : c.hiz;
    hiz_s_d = reset ? 1'b0 : hiz_m_q;
  end

  always_ff @(posedge clock)
  begin
    hiz_m_q <= hiz_m_d;
    hiz_s_q <= hiz_s_d;
  end

  assign ram_out_hiz = hiz_s_q;

  // checks on the controller and its pins
  tlr_five_a: assert property (@(posedge tck) disable iff (rst_q)
    tms_v [*5] |=> st_q == stap_pkg::ST_TLR) else $error("five ones did not reach reset state");

  idle_hold_a: assert property (@(posedge tck) disable iff (rst_q)
    st_q == stap_pkg::ST_IDLE && !tms_v |=> st_q == stap_pkg::ST_IDLE ##0 $stable(st_q))
    else $error("idle left without mode select");

  dr_walk_a: assert property (@(posedge tck) disable iff (rst_q)
    st_q == stap_pkg::ST_IDLE && tms_v ##1 !tms_v ##1 !tms_v |=> st_q == stap_pkg::ST_SHDR)
    else $error("data path walk wrong");

  oe_shift_a: assert property (@(posedge tck) disable iff (rst_q)
    oe_q == shift_now) else $error("output enable outside shift states");

  tdo_ir_a: assert property (@(posedge tck) disable iff (rst_q)
    st_q == stap_pkg::ST_SHIR ##1 st_q == stap_pkg::ST_SHIR |-> tdo_q == c.ir_so)
    else $error("instruction bit not on output");

  pull_up_a: assert property (@(posedge tck) disable iff (rst_q)
    !tms_driven && st_q == stap_pkg::ST_TLR |=> st_q == stap_pkg::ST_TLR)
    else $error("floating mode select left reset");

  hiz_reset_a: assert property (@(posedge clock)
    reset [*2] |=> !ram_out_hiz) else $error("outputs floated during reset");

  // watches the test-clock request, so the first sync flop keeps its single reader
  float_cross_a: assert property (@(posedge clock) disable iff (reset)
    $rose(c.hiz) |-> ##[1:3] ram_out_hiz) else $error("float request not passed on");

  // main scenarios
  scan_boundary_c: cover property (@(posedge tck) disable iff (rst_q)
    st_q == stap_pkg::ST_SHDR && c.hiz);
  update_ir_c: cover property (@(posedge tck) disable iff (rst_q)
    st_q == stap_pkg::ST_UPIR ##1 st_q == stap_pkg::ST_IDLE);
  tms_reset_c: cover property (@(posedge tck) disable iff (rst_q)
    st_q == stap_pkg::ST_SHDR ##1 tms_v [*5]);
  float_seen_c: cover property (@(posedge clock) disable iff (reset)
    $rose(ram_out_hiz));
  pull_float_c: cover property (@(posedge tck) disable iff (rst_q)
    !tms_driven && st_q == stap_pkg::ST_TLR);
endmodule
`default_nettype wire

// File: test/stap_jtag_ctl.sv
/*
  board test controller model: drives the link clock, mode select and data in.
  assumes: tck is parked low between frames; tdo is read just before each rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module stap_jtag_ctl (
  output var logic tck,
  output var logic tms_pin,
  output var logic tms_driven,
  output var logic tdi_pin,
  output var logic tdi_driven,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // idle levels: clock parked low, pins driven high
  initial
  begin
    tck        = 1'b0;
    tms_pin    = 1'b1;
    tms_driven = 1'b1;
    tdi_pin    = 1'b1;
    tdi_driven = 1'b1;
  end

  // release pins; a released pin toggles so a stale level never passes for the pull-up
  task automatic float_pins(input logic tms_off, input logic tdi_off);
    tms_driven = ~tms_off;
    tdi_driven = ~tdi_off;
  endtask

  // one 30 ns period: pins change after the falling edge, tdo read before the rising one
  // taken by rising edge
  task automatic step(input logic m, input logic d, output logic so, output logic oe);
    tms_pin = tms_driven ? m : ~tms_pin;
    tdi_pin = tdi_driven ? d : ~tdi_pin;
    #14;
    so  = tdo;
    oe  = tdo_oe;
    tck = 1'b1;
    #15;
    tck = 1'b0;
    #1;
  endtask

  task automatic moves(input logic [7:0] seq, input int n);
    logic so;
    logic oe;
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b0, so, oe);
  endtask

  // lsb first shift; the last bit leaves through exit1
  task automatic shift(input logic [47:0] din, input int n, output logic [47:0] dout, output logic oe_all);
    logic so;
    logic oe;
    dout   = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], so, oe);
      dout[i] = so;
      oe_all  = oe_all & oe;
    end
  endtask
endmodule
`default_nettype wire

// File: test/sram_jtag_tap_port_tb.sv
/*
  testbench of the sram test access port: reset, every code, pause, tms reset, floating pins.
  assumes: the controller model drives the link pins; ram clock, reset and ring pins come from here.
*/
`timescale 1ns/10ps
`default_nettype none
module sram_jtag_tap_port_tb;
  localparam int RING_W = 8;
  localparam int PLACE  = 2;
  // arbitrary identification value, presence bit set
  localparam logic [31:0] ID_CODE = 32'h3c5a_96e1;
  localparam logic [47:0] PAT     = 48'hc3a5_0f96_7e18;
  logic              clock;
  logic              reset;
  logic [RING_W-1:0] ring_pins;
  logic              tck;
  logic              tms_pin;
  logic              tms_driven;
  logic              tdi_pin;
  logic              tdi_driven;
  logic              tdo;
  logic              tdo_oe;
  logic              ram_out_hiz;
  int                fail_count;
  int                total_checks;

  stap_port #(.RING_W(RING_W), .PLACE(PLACE), .ID_CODE(ID_CODE)) i_dut (
    .clock(clock), .reset(reset), .tck(tck), .tms_pin(tms_pin), .tms_driven(tms_driven),
    .tdi_pin(tdi_pin), .tdi_driven(tdi_driven), .ring_pins(ring_pins), .tdo(tdo),
    .tdo_oe(tdo_oe), .ram_out_hiz(ram_out_hiz));
  stap_jtag_ctl i_ctl (
    .tck(tck), .tms_pin(tms_pin), .tms_driven(tms_driven), .tdi_pin(tdi_pin),
    .tdi_driven(tdi_driven), .tdo(tdo), .tdo_oe(tdo_oe));

  // ram clock, 10 ns
  always #5 clock = ~clock;

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // float output crosses two ram flops; four edges cover it
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask

  // enter a path from idle, shift, update, back to idle
  task automatic scan(input logic ir_path, input logic [47:0] din, input int n, output logic [47:0] dout);
    logic so;
    logic oe;
    logic oe_all;
    if (ir_path)
      i_ctl.moves(8'h03, 4);
    else
      i_ctl.moves(8'h01, 3);
    i_ctl.shift(din, n, dout, oe_all);
    check(oe_all, 1'b1);
    i_ctl.step(1'b1, 1'b0, so, oe);
    check(oe, 1'b0);
    i_ctl.step(1'b0, 1'b0, so, oe);
  endtask

  // reset needs tck edges to cross, so the model clocks during it
  task automatic t_reset();
    logic so;
    logic oe;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 3; i++)
      i_ctl.step(1'b1, 1'b0, so, oe);
    @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++)
      i_ctl.step(1'b1, 1'b0, so, oe);
    check(oe, 1'b0);
    @(posedge clock);
    ring_pins <= 8'hff;
    settle();
    check(ram_out_hiz, 1'b0);
    i_ctl.moves(8'h00, 1);
  endtask

  // every code: capture value, selected path, output float
  task automatic t_codes();
    logic [47:0] got;
    logic [47:0] want;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clock);
      ring_pins <= 8'ha5 ^ RING_W'(c);
      scan(1'b1, 48'(c), 3, got);
      check(got[2:0], 3'h1);
      settle();
      check(ram_out_hiz, c == 2);
      scan(1'b0, PAT, 48, got);
      case (c)
        1: want = {PAT[15:0], ID_CODE};
        2, 4: want = {PAT[47-RING_W-PLACE:0], {PLACE{1'b1}}, 8'ha5 ^ RING_W'(c)};
        default: want = {PAT[46:0], 1'b0};
      endcase
      check(got, want);
    end
  endtask

  // a code parked in pause-ir must not act before update-ir
  task automatic t_pause();
    logic [47:0] got;
    logic        oe_all;
    i_ctl.moves(8'h03, 4);
    i_ctl.shift(48'h2, 3, got, oe_all);
    i_ctl.moves(8'h00, 1);
    settle();
    check(ram_out_hiz, 1'b0);
    i_ctl.moves(8'h03, 3);
    settle();
    check(ram_out_hiz, 1'b1);
  endtask

  // exactly five ones from shift-dr, driven or left floating
  task automatic t_five(input logic drv);
    logic [47:0] got;
    scan(1'b1, 48'h2, 3, got);
    i_ctl.moves(8'h01, 3);
    i_ctl.float_pins(~drv, 1'b0);
    i_ctl.moves(8'h1f, 5);
    settle();
    check(ram_out_hiz, 1'b0);
    // one more edge, still floating when asked, must keep the reset state
    i_ctl.moves(8'h01, 1);
    i_ctl.float_pins(1'b0, 1'b0);
    i_ctl.moves(8'h00, 1);
    scan(1'b0, PAT, 48, got);
    check(got, {PAT[15:0], ID_CODE});
  endtask

  // floating data in reads as ones through bypass
  task automatic t_tdi_float();
    logic [47:0] got;
    scan(1'b1, 48'h0, 3, got);
    i_ctl.float_pins(1'b0, 1'b1);
    scan(1'b0, PAT, 48, got);
    i_ctl.float_pins(1'b0, 1'b0);
    check(got, {{47{1'b1}}, 1'b0});
  endtask

  // main sequence
  initial
  begin
    clock        = 1'b0;
    reset        = 1'b1;
    ring_pins    = '0;
    fail_count   = 0;
    total_checks = 0;
    t_reset();
    t_codes();
    t_pause();
    t_five(1'b0);
    t_five(1'b1);
    t_tdi_float();
    summarize();
  end

  // bound on the whole run, in case a scan hangs
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
